// ### rtl/ucm_top.sv
`timescale 1ns/10ps
`include "ucm_map.svh"
module ucm_top
    import ucm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic tick_16x,
    input wire logic bit_clock_1x,
    input wire logic sample_38k_tick,
    input wire logic crystal_clock_input,
    input wire logic bus_mode_68k,
    input wire logic [6:0] general_input,
    input wire logic rxd,
    output logic txd,
    output logic [7:0] general_output,
    output logic interrupt_output_n
);
    // Pointer step that wraps at the selected depth
    function automatic logic [3:0] ucm_next(input logic [3:0] p,
                                            input logic deep);
        ucm_next = deep ? p + 4'h1 : {1'b0, p[2:0] + 3'h1};
    endfunction : ucm_next

    function automatic logic ucm_parity(input logic [7:0] d,
                                        input logic [1:0] len,
                                        input logic odd);
        ucm_parity = (^(d & (8'hFF >> (2'h3 - len)))) ^ odd;
    endfunction : ucm_parity

    logic [7:0] mode_q, mode_d, mode2_q, mode2_d, output_source_config_q, output_source_config_d;
    logic [7:0] cfg_q, cfg_d, imsk_q, imsk_d, latch_q, latch_d;
    logic rx_en_q, rx_en_d, tx_en_q, tx_en_d, brk_q, brk_d;
    logic bclk_q, xtal_q, rx_prev_q, bclk_rise, xtal_edge;
    logic cmd_wr, cmd_txen, cmd_txrst, cmd_rxrst, wr_data, rd_data;
    logic [4:0] depth;
    logic x16;

    assign cmd_wr = wr_en && addr == `UCM_A_CMD;
    assign cmd_txen = cmd_wr && wdata[`UCM_C_TXEN];
    assign cmd_txrst = cmd_wr && wdata[`UCM_C_TXRST];
    assign cmd_rxrst = cmd_wr && wdata[`UCM_C_RXRST];
    assign wr_data = wr_en && addr == `UCM_A_DATA;
    assign rd_data = rd_en && addr == `UCM_A_DATA;
    assign depth = cfg_q[0] ? 5'h10 : 5'h08;
    assign x16 = mode_q[`UCM_M_X16];
    assign bclk_rise = bit_clock_1x && !bclk_q;
    assign xtal_edge = crystal_clock_input ^ xtal_q;

    // Edge reference copies of the slow pins
    always_ff @(posedge clk) begin
        if (srst) begin
            bclk_q <= 1'b0;
            xtal_q <= 1'b0;
            rx_prev_q <= 1'b1;
        end else begin
            bclk_q <= bit_clock_1x;
            xtal_q <= crystal_clock_input;
            rx_prev_q <= rxd;
        end
    end

    // Transmitter state
    ucm_tx_st_t tx_st_q, tx_st_d;
    logic [7:0] tx_mem_q [16];
    logic [3:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d, tx_sub_q, tx_sub_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic tx_par_q, tx_par_d, tx_stop_q, tx_stop_d, txd_q, txd_d;
    logic tx_emt_q, tx_emt_d, tx_push, tx_pop, tx_tick, tx_full, tx_rdy;
    logic tx_drained;

    assign tx_full = tx_cnt_q == depth;
    assign tx_rdy = tx_en_q && !tx_full;
    assign tx_drained = tx_st_q == TX_IDLE && tx_cnt_q == 5'h00;
    assign tx_tick = x16 ? (tick_16x && tx_sub_q == `UCM_TICK_LAST)
                         : bclk_rise;

    // Commands and software-written configuration
    always_comb begin
        mode_d = mode_q;
        mode2_d = mode2_q;
        output_source_config_d = output_source_config_q;
        cfg_d = cfg_q;
        imsk_d = imsk_q;
        latch_d = latch_q;
        rx_en_d = rx_en_q;
        tx_en_d = tx_en_q;
        brk_d = brk_q;
        if (wr_en) begin
            case (addr)
                `UCM_A_MODE: mode_d = wdata;
                `UCM_A_MODE2: mode2_d = wdata;
                `UCM_A_OUTPUT_SOURCE_CONFIG: output_source_config_d = wdata;
                `UCM_A_CFG: cfg_d = wdata;
                `UCM_A_IMSK: imsk_d = wdata;
                `UCM_A_OPSET: latch_d = latch_q | wdata;
                `UCM_A_OPCLR: latch_d = latch_q & ~wdata;
                `UCM_A_CMD: begin
                    if (wdata[`UCM_C_RXEN]) rx_en_d = 1'b1;
                    if (wdata[`UCM_C_RXDIS]) rx_en_d = 1'b0;
                    if (wdata[`UCM_C_TXEN]) tx_en_d = 1'b1;
                    if (wdata[`UCM_C_TXDIS]) tx_en_d = 1'b0;
                    if (wdata[`UCM_C_BRKON]) brk_d = 1'b1;
                    if (wdata[`UCM_C_BRKOFF]) brk_d = 1'b0;
                    if (wdata[`UCM_C_TXRST]) begin
                        tx_en_d = 1'b0;
                        brk_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // End of message: drop request-to-send once fully drained
        if (mode2_q[`UCM_M2_RTS] && !tx_en_q && tx_drained) begin
            latch_d[0] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= `UCM_MODE_RST;
            mode2_q <= `UCM_MODE2_RST;
            output_source_config_q <= `UCM_OUTPUT_SOURCE_CONFIG_RST;
            cfg_q <= `UCM_CFG_RST;
            imsk_q <= `UCM_IMSK_RST;
            latch_q <= `UCM_LATCH_RST;
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mode2_q <= mode2_d;
            output_source_config_q <= output_source_config_d;
            cfg_q <= cfg_d;
            imsk_q <= imsk_d;
            latch_q <= latch_d;
            rx_en_q <= rx_en_d;
            tx_en_q <= tx_en_d;
            brk_q <= brk_d;
        end
    end

    // Transmit FIFO and serialiser; keeps draining after a disable
    always_comb begin
        tx_st_d = tx_st_q;
        tx_wp_d = tx_wp_q;
        tx_rp_d = tx_rp_q;
        tx_cnt_d = tx_cnt_q;
        tx_sh_d = tx_sh_q;
        tx_bit_d = tx_bit_q;
        tx_par_d = tx_par_q;
        tx_stop_d = tx_stop_q;
        tx_emt_d = tx_emt_q;
        tx_sub_d = tick_16x ? tx_sub_q + 4'h1 : tx_sub_q;
        tx_push = wr_data && tx_rdy;
        tx_pop = 1'b0;
        case (tx_st_q)
            TX_IDLE: begin
                tx_sub_d = 4'h0;
                // CTS is looked at only here, between characters
                if (tx_cnt_q != 5'h00 && !(mode2_q[`UCM_M2_CTS] &&
                    general_input[0])) begin
                    tx_pop = 1'b1;
                    tx_sh_d = tx_mem_q[tx_rp_q];
                    tx_par_d = ucm_parity(tx_mem_q[tx_rp_q], mode_q[1:0],
                                          mode_q[`UCM_M_PARODD]);
                    tx_st_d = TX_START;
                end
            end
            TX_START: if (tx_tick) begin
                tx_bit_d = 3'h0;
                tx_st_d = TX_DATA;
            end
            TX_DATA: if (tx_tick) begin
                tx_sh_d = {1'b0, tx_sh_q[7:1]};
                tx_bit_d = tx_bit_q + 3'h1;
                if (tx_bit_q == {1'b0, mode_q[1:0]} + 3'h4) begin
                    tx_st_d = mode_q[`UCM_M_PAREN] ? TX_PAR : TX_STOP;
                    tx_stop_d = 1'b0;
                end
            end
            TX_PAR: if (tx_tick) begin
                tx_st_d = TX_STOP;
                tx_stop_d = 1'b0;
            end
            TX_STOP: if (tx_tick) begin
                tx_stop_d = 1'b1;
                if (tx_stop_q || !mode_q[`UCM_M_STOP2]) begin
                    tx_st_d = TX_IDLE;
                    if (tx_cnt_q == 5'h00) tx_emt_d = 1'b1;
                end
            end
            default: tx_st_d = TX_IDLE;
        endcase
        if (tx_push) begin
            tx_wp_d = ucm_next(tx_wp_q, cfg_q[0]);
            tx_emt_d = 1'b0;
        end
        if (tx_pop) tx_rp_d = ucm_next(tx_rp_q, cfg_q[0]);
        tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
        if (cmd_txen) tx_emt_d = 1'b1;
        if (cmd_txrst) begin
            tx_st_d = TX_IDLE;
            tx_wp_d = 4'h0;
            tx_rp_d = 4'h0;
            tx_cnt_d = 5'h00;
            tx_emt_d = 1'b0;
        end
        case (tx_st_q)
            TX_START: txd_d = 1'b0;
            TX_DATA: txd_d = tx_sh_q[0];
            TX_PAR: txd_d = tx_par_q;
            default: txd_d = 1'b1;
        endcase
        if (brk_q) txd_d = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_st_q <= TX_IDLE;
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
            tx_sh_q <= 8'h00;
            tx_bit_q <= 3'h0;
            tx_par_q <= 1'b0;
            tx_stop_q <= 1'b0;
            tx_emt_q <= 1'b0;
            tx_sub_q <= 4'h0;
            txd_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            tx_cnt_q <= tx_cnt_d;
            tx_sh_q <= tx_sh_d;
            tx_bit_q <= tx_bit_d;
            tx_par_q <= tx_par_d;
            tx_stop_q <= tx_stop_d;
            tx_emt_q <= tx_emt_d;
            tx_sub_q <= tx_sub_d;
            txd_q <= txd_d;
        end
        if (tx_push) tx_mem_q[tx_wp_q] <= wdata;
    end

    // Receiver state
    ucm_rx_st_t rx_st_q, rx_st_d;
    logic [10:0] rx_mem_q [16];
    logic [10:0] hold_q, hold_d, rx_word, rx_top;
    logic [3:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d, rx_sub_q, rx_sub_d;
    logic [4:0] rx_cnt_q, rx_cnt_d;
    logic [7:0] rx_sh_q, rx_sh_d, rx_data;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [1:0] xe_q, xe_d;
    logic rx_pbit_q, rx_pbit_d, held_q, held_d, ovr_q, ovr_d;
    logic rx_smp, rx_push, rx_pop, rx_full, rx_rdy, rx_zero;

    assign rx_full = rx_cnt_q == depth;
    assign rx_rdy = rx_cnt_q != 5'h00;
    assign rx_top = rx_rdy ? rx_mem_q[rx_rp_q] : 11'h000;
    assign rx_data = (rx_sh_q >> (2'h3 - mode_q[1:0]));
    assign rx_zero = rx_data == 8'h00 &&
                     !(mode_q[`UCM_M_PAREN] && rx_pbit_q);
    // Bit centres fall at count 7 of a counter zeroed at the edge
    assign rx_smp = x16 ? (tick_16x && rx_sub_q == `UCM_TICK_HALF)
                        : bclk_rise;

    always_comb begin
        rx_st_d = rx_st_q;
        rx_wp_d = rx_wp_q;
        rx_rp_d = rx_rp_q;
        rx_cnt_d = rx_cnt_q;
        rx_sh_d = rx_sh_q;
        rx_bit_d = rx_bit_q;
        rx_pbit_d = rx_pbit_q;
        hold_d = hold_q;
        held_d = held_q;
        ovr_d = ovr_q;
        xe_d = xe_q;
        rx_sub_d = tick_16x ? rx_sub_q + 4'h1 : rx_sub_q;
        rx_word = {3'h0, rx_data};
        rx_push = 1'b0;
        rx_pop = rd_data && rx_rdy;
        case (rx_st_q)
            RX_IDLE: if (rx_prev_q && !rxd) begin
                rx_sub_d = 4'h0;
                rx_st_d = RX_START;
            end
            RX_START: if (rx_smp) begin
                if (rxd) begin
                    rx_st_d = RX_IDLE;
                end else begin
                    rx_st_d = RX_DATA;
                    rx_bit_d = 3'h0;
                    rx_pbit_d = 1'b0;
                    if (held_q) begin
                        held_d = 1'b0;
                        ovr_d = 1'b1;
                    end
                end
            end
            RX_DATA: if (rx_smp) begin
                rx_sh_d = {rxd, rx_sh_q[7:1]};
                rx_bit_d = rx_bit_q + 3'h1;
                if (rx_bit_q == {1'b0, mode_q[1:0]} + 3'h4) begin
                    rx_st_d = mode_q[`UCM_M_PAREN] ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: if (rx_smp) begin
                rx_pbit_d = rxd;
                rx_st_d = RX_STOP;
            end
            RX_STOP: if (rx_smp) begin
                rx_word[8] = mode_q[`UCM_M_PAREN] && (rx_pbit_q !=
                    ucm_parity(rx_data, mode_q[1:0], mode_q[`UCM_M_PARODD]));
                rx_push = 1'b1;
                if (rxd) begin
                    rx_st_d = RX_IDLE;
                end else if (rx_zero) begin
                    rx_word = 11'h400;
                    xe_d = 2'h0;
                    rx_st_d = RX_BRK;
                end else begin
                    rx_word[9] = 1'b1;
                    rx_st_d = RX_HALF;
                end
            end
            RX_HALF: if (x16 ? (tick_16x && rx_sub_q == `UCM_TICK_LAST)
                             : bclk_rise) begin
                rx_sub_d = 4'h0;
                rx_st_d = rxd ? RX_IDLE : RX_START;
            end
            RX_BRK: begin
                // Line must stay high across two crystal edges
                if (!rxd) xe_d = 2'h0;
                else if (xtal_edge) xe_d = xe_q + 2'h1;
                if (xe_q == `UCM_XTAL_EDGES) rx_st_d = RX_IDLE;
            end
            default: rx_st_d = RX_IDLE;
        endcase
        // Full FIFO parks the new character in the holding slot
        if (rx_push && rx_full) begin
            rx_push = 1'b0;
            hold_d = rx_word;
            held_d = 1'b1;
        end else if (held_q && !rx_full && rx_st_q != RX_START) begin
            rx_push = 1'b1;
            rx_word = hold_q;
            held_d = 1'b0;
        end
        if (rx_push) rx_wp_d = ucm_next(rx_wp_q, cfg_q[0]);
        if (rx_pop) rx_rp_d = ucm_next(rx_rp_q, cfg_q[0]);
        rx_cnt_d = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
        if (!rx_en_q) rx_st_d = RX_IDLE;
        if (cmd_rxrst) begin
            rx_st_d = RX_IDLE;
            rx_wp_d = 4'h0;
            rx_rp_d = 4'h0;
            rx_cnt_d = 5'h00;
            held_d = 1'b0;
            ovr_d = 1'b0;
            rx_push = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_st_q <= RX_IDLE;
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
            rx_sh_q <= 8'h00;
            rx_bit_q <= 3'h0;
            rx_pbit_q <= 1'b0;
            hold_q <= 11'h000;
            held_q <= 1'b0;
            ovr_q <= 1'b0;
            xe_q <= 2'h0;
            rx_sub_q <= 4'h0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            rx_cnt_q <= rx_cnt_d;
            rx_sh_q <= rx_sh_d;
            rx_bit_q <= rx_bit_d;
            rx_pbit_q <= rx_pbit_d;
            hold_q <= hold_d;
            held_q <= held_d;
            ovr_q <= ovr_d;
            xe_q <= xe_d;
            rx_sub_q <= rx_sub_d;
        end
        if (rx_push) rx_mem_q[rx_wp_q] <= rx_word;
    end

    // Change detectors; a set in the clearing read cycle survives
    logic [3:0] smp_q, smp_d, acc_q, acc_d, chg_q, chg_d, chg_set;
    always_comb begin
        smp_d = smp_q;
        acc_d = acc_q;
        chg_set = 4'h0;
        if (sample_38k_tick) begin
            smp_d = general_input[3:0];
            chg_set = ~(general_input[3:0] ^ smp_q) &
                      (general_input[3:0] ^ acc_q);
            acc_d = acc_q ^ chg_set;
        end
        chg_d = ((rd_en && addr == `UCM_A_CHG) ? 4'h0 : chg_q) |
                chg_set;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            smp_q <= 4'h0;
            acc_q <= 4'h0;
            chg_q <= 4'h0;
        end else begin
            smp_q <= smp_d;
            acc_q <= acc_d;
            chg_q <= chg_d;
        end
    end

    // Read mux, output pins and interrupt line, all registered
    logic [7:0] rdata_d, op_d;
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en) begin
            case (addr)
                `UCM_A_MODE: rdata_d = mode_q;
                `UCM_A_MODE2: rdata_d = mode2_q;
                `UCM_A_STAT: rdata_d = {rx_top[10:8], ovr_q, tx_emt_q,
                                        tx_rdy, rx_full, rx_rdy};
                `UCM_A_DATA: rdata_d = rx_top[7:0];
                `UCM_A_OUTPUT_SOURCE_CONFIG: rdata_d = output_source_config_q;
                `UCM_A_CHG: rdata_d = {acc_q, chg_q};
                `UCM_A_CFG: rdata_d = cfg_q;
                `UCM_A_IMSK: rdata_d = imsk_q;
                `UCM_A_INPUT: rdata_d = {1'b1,
                    general_input[6] && !bus_mode_68k,
                    general_input[5:0]};
                default: rdata_d = 8'h00;
            endcase
        end
        op_d = ~latch_q;
        if (output_source_config_q[2]) op_d[2] = txd_q;
        if (output_source_config_q[3]) op_d[3] = ~|chg_q;
        if (output_source_config_q[4]) op_d[4] = !rx_rdy;
        if (output_source_config_q[5]) op_d[5] = !rx_full;
        if (output_source_config_q[6]) op_d[6] = !tx_rdy;
        if (output_source_config_q[7]) op_d[7] = !tx_emt_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            general_output <= 8'hFF;
            interrupt_output_n <= 1'b1;
        end else begin
            rdata <= rdata_d;
            general_output <= op_d;
            interrupt_output_n <= !(|(imsk_q[3:0] &
                {rx_full, |chg_q, rx_rdy, tx_rdy}));
        end
    end
    assign txd = txd_q;

    default clocking ucm_cb @(posedge clk); endclocking
    default disable iff (srst);

    a_input_read: assert property (rd_en && addr == `UCM_A_INPUT |=>
        rdata[7] && rdata[5:0] == $past(general_input[5:0]))
        else $error("input level read wrong");
    a_change_tick: assert property ($rose(chg_q[0]) |->
        $past(sample_38k_tick) && $past(smp_q[0]) == acc_q[0])
        else $error("change set without two samples");
    a_latch_invert: assert property (!output_source_config_q[7] |=>
        general_output[7] == !$past(latch_q[7]))
        else $error("output pin not inverted latch");
    a_set_bits: assert property (wr_en && addr == `UCM_A_OPSET |=>
        latch_q[7:1] == ($past(latch_q[7:1]) | $past(wdata[7:1])))
        else $error("set command wrong");
    a_tx_refused: assert property (wr_en && addr == `UCM_A_DATA &&
        !tx_en_q |=> tx_cnt_q <= $past(tx_cnt_q))
        else $error("write accepted while disabled");
    a_break_low: assert property (brk_q ##1 brk_q |-> !txd_q)
        else $error("break not low");
    a_start_low: assert property (tx_st_q == TX_START &&
        $past(tx_st_q) == TX_IDLE |=> !txd_q)
        else $error("start bit not low");
    a_cts_hold: assert property (tx_st_q == TX_IDLE && !cmd_txrst &&
        mode2_q[`UCM_M2_CTS] && general_input[0] |=> tx_st_q == TX_IDLE)
        else $error("character sent with cts high");
    a_rx_overrun: assert property (rx_st_q == RX_START && rx_smp &&
        !rxd && held_q && rx_en_q && !cmd_rxrst |=> ovr_q && !held_q)
        else $error("overrun not flagged");
    a_tx_ready: assert property (rd_en && addr == `UCM_A_STAT |=>
        rdata[`UCM_S_TRANSMIT_READY_FLAG] == $past(tx_en_q && !tx_full))
        else $error("transmit ready wrong");
    a_rx_reset: assert property (cmd_rxrst |=> !rx_rdy &&
        rx_st_q == RX_IDLE ##1 rx_wp_q == rx_rp_q || rx_rdy)
        else $error("receive reset incomplete");

    c_tx_frame: cover property (tx_st_q == TX_STOP ##1 tx_st_q == TX_IDLE);
    c_rx_push: cover property (rx_push && !rx_word[10]);
    c_rx_break: cover property (rx_st_q == RX_BRK ##1 rx_st_q == RX_IDLE);
    c_change: cover property (|chg_set);
endmodule : ucm_top

// ### rtl/ucm_map.svh
`ifndef UCM_MAP_SVH
`define UCM_MAP_SVH
`define UCM_A_MODE 4'h0
`define UCM_A_MODE2 4'h1
`define UCM_A_CMD 4'h2
`define UCM_A_STAT 4'h3
`define UCM_A_DATA 4'h4
`define UCM_A_OUTPUT_SOURCE_CONFIG 4'h5
`define UCM_A_CHG 4'h6
`define UCM_A_CFG 4'h7
`define UCM_A_IMSK 4'h8
`define UCM_A_INPUT 4'hD
`define UCM_A_OPSET 4'hE
`define UCM_A_OPCLR 4'hF
`define UCM_M_PAREN 2
`define UCM_M_PARODD 3
`define UCM_M_STOP2 6
`define UCM_M_X16 7
`define UCM_M2_CTS 4
`define UCM_M2_RTS 5
`define UCM_C_RXEN 0
`define UCM_C_RXDIS 1
`define UCM_C_TXEN 2
`define UCM_C_TXDIS 3
`define UCM_C_RXRST 4
`define UCM_C_TXRST 5
`define UCM_C_BRKON 6
`define UCM_C_BRKOFF 7
`define UCM_S_RECEIVE_READY_FLAG 0
`define UCM_S_FIFO_FULL_FLAG 1
`define UCM_S_TRANSMIT_READY_FLAG 2
`define UCM_S_TXEMT 3
`define UCM_S_OVR 4
`define UCM_MODE_RST 8'h83
`define UCM_MODE2_RST 8'h00
`define UCM_OUTPUT_SOURCE_CONFIG_RST 8'h00
`define UCM_CFG_RST 8'h01
`define UCM_IMSK_RST 8'h00
`define UCM_LATCH_RST 8'h00
`define UCM_TICK_HALF 4'h7
`define UCM_TICK_LAST 4'hF
`define UCM_XTAL_EDGES 2'h2
`endif

// ### rtl/ucm_pkg.sv
package ucm_pkg;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } ucm_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HALF, RX_BRK
    } ucm_rx_st_t;
endpackage : ucm_pkg

// ### test/ucm_remote.sv
`timescale 1ns/10ps
module ucm_remote (
    input wire logic clk,
    input wire logic tick_16x,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got_byte;
    int got_n;
    // One bit lasts 16 enables, as the far station counts them
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff tick_16x);
    endtask : ticks
    // Start low, data LSB first, stop high; line rests high after
    task automatic send(input logic [7:0] b);
        rxd <= 1'b0;
        ticks(16);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            ticks(16);
        end
        rxd <= 1'b1;
        ticks(16);
    endtask : send
    initial begin
        rxd = 1'b1;
        got_n = 0;
        got_byte = 8'h00;
    end
    // Sample at bit centres, half a bit after the start edge
    always begin
        @(negedge txd);
        ticks(8);
        for (int i = 0; i < 8; i++) begin
            ticks(16);
            got_byte[i] = txd;
        end
        ticks(16);
        got_n++;
    end
endmodule : ucm_remote

// ### test/ucm_top_tb.sv
`timescale 1ns/10ps
module ucm_top_tb;
    logic clk, srst, wr_en, rd_en, tick_16x, bus_mode_68k, txd, rxd, irq_n;
    logic [3:0] addr;
    logic [1:0] tcnt = 2'h0;
    logic [7:0] wdata, rdata, general_output, seen;
    logic [6:0] general_input;
    int fail_count, n_compared;
    // Tie-offs: 1x clock and crystal unused; change sampling rides 16x
    ucm_top ucm_top_i (.clk, .srst, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .tick_16x, .bit_clock_1x(1'b0), .sample_38k_tick(tick_16x),
        .crystal_clock_input(1'b0), .bus_mode_68k, .general_input, .rxd,
        .txd, .general_output, .interrupt_output_n(irq_n));
    ucm_remote ucm_remote_i (.clk, .tick_16x, .txd, .rxd);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Baud enable every fourth clock keeps frames short
    always @(posedge clk) begin
        tcnt <= tcnt + 2'h1;
        tick_16x <= (tcnt == 2'h0);
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 seen = rdata;
    endtask : rd
    task automatic pins(input logic [7:0] e);
        repeat (2) @(posedge clk);
        #1 chk(general_output, e);
    endtask : pins
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic t_ports;
        chk(general_output, 8'hFF);
        chk({7'h00, txd}, 8'h01);
        @(posedge clk);
        general_input <= 7'h55;
        rd(4'hD);
        chk(seen, 8'hD5);
        @(posedge clk);
        bus_mode_68k <= 1'b1;
        rd(4'hD);
        chk(seen, 8'h95);
        rd(4'h9);
        chk(seen, 8'h00);
        wr(4'hE, 8'hA5);
        pins(8'h5A);
        wr(4'hF, 8'h81);
        pins(8'hDB);
        $display("ports test done");
    endtask : t_ports
    // Transmit one byte, then receive one from the far station
    task automatic t_serial;
        wr(4'h2, 8'h05);
        wr(4'h4, 8'hC3);
        for (int i = 0; i < 2000 && ucm_remote_i.got_n == 0; i++)
            @(posedge clk);
        chk(ucm_remote_i.got_byte, 8'hC3);
        ucm_remote_i.send(8'h3C);
        repeat (40) @(posedge clk);
        rd(4'h3);
        chk({7'h00, seen[0]}, 8'h01);
        rd(4'h4);
        chk(seen, 8'h3C);
        rd(4'h3);
        chk({7'h00, seen[0]}, 8'h00);
        $display("serial test done");
    endtask : t_serial
    // Change bits, interrupt line, refused write, CTS hold, break
    task automatic t_events;
        rd(4'h6);
        chk(seen, 8'h55);
        rd(4'h6);
        chk(seen, 8'h50);
        wr(4'h8, 8'h04);
        general_input <= 7'h54;
        repeat (12) @(posedge clk);
        #1 chk({7'h00, irq_n}, 8'h00);
        rd(4'h6);
        chk(seen, 8'h41);
        @(posedge clk);
        #1 chk({7'h00, irq_n}, 8'h01);
        wr(4'h2, 8'h08);
        wr(4'h4, 8'hAA);
        rd(4'h3);
        chk(seen, 8'h08);
        wr(4'h1, 8'h10);
        general_input <= 7'h55;
        wr(4'h2, 8'h04);
        wr(4'h4, 8'h81);
        repeat (40) @(posedge clk);
        #1 chk({7'h00, txd}, 8'h01);
        @(posedge clk);
        general_input <= 7'h54;
        for (int i = 0; i < 2000 && ucm_remote_i.got_n < 2; i++)
            @(posedge clk);
        chk(ucm_remote_i.got_byte, 8'h81);
        wr(4'h2, 8'h40);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, txd}, 8'h00);
        wr(4'h2, 8'h80);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, txd}, 8'h01);
        $display("event test done");
    endtask : t_events
    initial begin
        {srst, wr_en, rd_en, bus_mode_68k} = 4'h8;
        {addr, wdata, general_input} = '0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_ports();
        t_serial();
        t_events();
        wrap_up();
    end
    // Hang guard well beyond all three tests together
    initial begin
        #60000;
        fail_count++;
        wrap_up();
    end
endmodule : ucm_top_tb
